// >>> core/pmt_decode.sv
// Opcode decoder for the table read and table write instructions
module pmt_decode
  import pmt_pkg::*;
(
  // Instruction word
  input  wire logic [pmt_pkg::PMT_OPC_W-1:0] opcode,
  // Decoded result
  output logic                               is_read,
  output logic                               is_write,
  output pmt_pkg::pmt_mode_t                 mode
);
  import pmt_pkg::*;

  wire fixed_ok;

  assign fixed_ok = (opcode[15:4] == PMT_OPC_HIGH) && opcode[PMT_OPC_ONE_BIT];
  assign is_read  = fixed_ok && !opcode[PMT_OPC_DIR_BIT];
  assign is_write = fixed_ok && opcode[PMT_OPC_DIR_BIT];
  assign mode     = pmt_mode_t'(opcode[PMT_OPC_MODE_LSB +: 2]);

endmodule

// >>> core/pmt_pkg.sv
// Shared constants and types of the program memory table access unit
package pmt_pkg;

  localparam int PMT_PTR_W   = 21;
  localparam int PMT_DATA_W  = 8;
  localparam int PMT_HOLD_N  = 8;
  localparam int PMT_HOLD_W  = 3;
  localparam int PMT_OPC_W   = 16;

  // Thirteen fixed opcode bits; bit 2 tells read from write
  localparam logic [13:0] PMT_OPC_FIXED = 14'h0002;
  localparam logic [11:0] PMT_OPC_HIGH  = 12'h000;
  localparam int          PMT_OPC_MODE_LSB = 0;
  localparam int          PMT_OPC_DIR_BIT  = 2;
  localparam int          PMT_OPC_ONE_BIT  = 3;

  localparam logic [PMT_PTR_W-1:0]  PMT_PTR_RST   = 21'h000000;
  localparam logic [PMT_DATA_W-1:0] PMT_LATCH_RST = 8'h00;
  localparam logic [PMT_PTR_W-1:0]  PMT_PTR_ONE   = 21'h000001;

  typedef enum logic [1:0] {
    PMT_MODE_KEEP,
    PMT_MODE_POST_INC,
    PMT_MODE_POST_DEC,
    PMT_MODE_PRE_INC
  } pmt_mode_t;

  typedef enum {
    PMT_IDLE,
    PMT_SECOND
  } pmt_state_t;

  // Request from the execution pipeline
  typedef struct packed {
    logic                    valid;
    logic [PMT_OPC_W-1:0]    opcode;
    logic [PMT_DATA_W-1:0]   wr_latch;
    logic                    wr_latch_en;
    logic [PMT_PTR_W-1:0]    wr_ptr;
    logic                    wr_ptr_en;
  } pmt_req_t;

  // Access toward the program flash array
  typedef struct packed {
    logic                    rd_en;
    logic [PMT_PTR_W-2:0]    word_addr;
  } pmt_mem_t;

endpackage

// >>> core/pmt_ptr_step.sv
// Pointer update arithmetic for the four pointer modes
module pmt_ptr_step
  import pmt_pkg::*;
(
  // Current pointer and mode
  input  wire logic [pmt_pkg::PMT_PTR_W-1:0] ptr,
  input  wire pmt_pkg::pmt_mode_t            mode,
  // Address used for the access and pointer after the instruction
  output logic [pmt_pkg::PMT_PTR_W-1:0]      access_addr,
  output logic [pmt_pkg::PMT_PTR_W-1:0]      ptr_after
);
  import pmt_pkg::*;

  wire [PMT_PTR_W-1:0] ptr_inc;
  wire [PMT_PTR_W-1:0] ptr_dec;

  // Wraps within the 2 Mbyte space
  assign ptr_inc = ptr + PMT_PTR_ONE;
  assign ptr_dec = ptr - PMT_PTR_ONE;

  // Only pre-increment accesses the moved address
  assign access_addr = (mode == PMT_MODE_PRE_INC) ? ptr_inc : ptr;

  assign ptr_after = (mode == PMT_MODE_KEEP)     ? ptr     :
                     (mode == PMT_MODE_POST_DEC) ? ptr_dec :
                     ptr_inc;

endmodule

// >>> core/pmt_table_access.sv
// Table read and table write unit between the execution pipeline and program flash
// What this block does
// - Decode fixed opcode with two-bit pointer mode
// - Mode 0 reads byte, pointer unchanged
// - Post-increment: read byte, then pointer plus one
// - Post-decrement: read byte, then pointer minus one
// - Pre-increment: pointer plus one, then read
// - Pointer is 21 bits, byte addressed
// - Pointer bit zero picks high or low byte
// - Address comes only from the pointer
// - Write stores latch in holding register
// - Holding registers buffer data, flash untouched
// - Write uses same pointer mode semantics
module pmt_table_access
  import pmt_pkg::*;
(
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  // Execution pipeline request
  input  wire pmt_pkg::pmt_req_t                   req,
  output logic                                     busy,
  output logic                                     done,
  // Architectural state
  output logic [pmt_pkg::PMT_PTR_W-1:0]            table_pointer,
  output logic [pmt_pkg::PMT_DATA_W-1:0]           table_latch,
  // Program flash read port, data valid the cycle after rd_en
  output pmt_pkg::pmt_mem_t                        mem,
  input  wire logic [15:0]                         mem_word,
  // Holding registers toward the programming sequencer
  output logic [pmt_pkg::PMT_HOLD_N*pmt_pkg::PMT_DATA_W-1:0] hold_data
);
  import pmt_pkg::*;

  pmt_state_t          state;
  pmt_state_t          next_state;
  logic                is_read;
  logic                is_write;
  pmt_mode_t           mode;
  logic [PMT_PTR_W-1:0] access_addr;
  logic [PMT_PTR_W-1:0] ptr_after;
  logic                 op_read;
  logic                 op_write;
  logic                 byte_sel;
  logic [PMT_HOLD_W-1:0] hold_idx;
  logic [PMT_DATA_W-1:0] hold_mem [PMT_HOLD_N];

  wire start;
  wire [PMT_DATA_W-1:0] fetched_byte;
  wire [PMT_HOLD_W-1:0] ptr_low;

  pmt_decode u_decode (
    .opcode   (req.opcode),
    .is_read  (is_read),
    .is_write (is_write),
    .mode     (mode)
  );

  pmt_ptr_step u_step (
    .ptr         (table_pointer),
    .mode        (mode),
    .access_addr (access_addr),
    .ptr_after   (ptr_after)
  );

  assign start      = req.valid && (state == PMT_IDLE) && (is_read || is_write);
  assign busy       = (state == PMT_SECOND);
  assign done       = (state == PMT_SECOND);
  assign next_state = start ? PMT_SECOND : PMT_IDLE;

  // Flash read is word wide; address has no operand field
  assign mem.rd_en     = start && is_read;
  assign mem.word_addr = access_addr[PMT_PTR_W-1:1];

  assign fetched_byte = byte_sel ? mem_word[15:8] : mem_word[7:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PMT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // First cycle: capture operation and address, update pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_read  <= 1'b0;
      op_write <= 1'b0;
      byte_sel <= 1'b0;
      hold_idx <= '0;
    end else begin
      op_read  <= start && is_read;
      op_write <= start && is_write;
      if (start) begin
        byte_sel <= access_addr[0];
        hold_idx <= access_addr[PMT_HOLD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      table_pointer <= PMT_PTR_RST;
    end else if (start) begin
      table_pointer <= ptr_after;
    end else if (req.wr_ptr_en && state == PMT_IDLE) begin
      table_pointer <= req.wr_ptr;
    end
  end

  // Second cycle: latch the byte or store the latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      table_latch <= PMT_LATCH_RST;
    end else if (op_read) begin
      table_latch <= fetched_byte;
    end else if (req.wr_latch_en && state == PMT_IDLE) begin
      table_latch <= req.wr_latch;
    end
  end

  // Holding registers only; the flash array is not written here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PMT_HOLD_N; i++) begin
        hold_mem[i] <= PMT_LATCH_RST;
      end
    end else if (op_write) begin
      hold_mem[hold_idx] <= table_latch;
    end
  end

  for (genvar g = 0; g < PMT_HOLD_N; g++) begin : g_hold
    assign hold_data[g*PMT_DATA_W +: PMT_DATA_W] = hold_mem[g];
  end

  // Sizes that the datapath cannot serve are refused at elaboration
  if (PMT_HOLD_N != (1 << PMT_HOLD_W)) begin : g_bad_hold
    $error("holding register count does not match its index width");
  end
  if (PMT_PTR_W <= PMT_HOLD_W) begin : g_bad_ptr
    $error("pointer too narrow to select a holding register");
  end
  if (2 * PMT_DATA_W != 16) begin : g_bad_word
    $error("flash word must carry exactly two table bytes");
  end
  if (PMT_OPC_W != 16) begin : g_bad_opc
    $error("opcode must be one 16 bit program word");
  end

  // Assertions
  // Low pointer bits, sampled by the holding register checks
  assign ptr_low = table_pointer[PMT_HOLD_W-1:0];

  sequence s_start_read;
    start && is_read;
  endsequence

  sequence s_start_write;
    start && is_write;
  endsequence

  AST_TWO_CYCLES: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> done ##1 !done)
    else $error("table access did not take two cycles");

  AST_KEEP_PTR: assert property (@(posedge clk) disable iff (!rst_b)
    start && mode == PMT_MODE_KEEP |=> table_pointer == $past(table_pointer))
    else $error("pointer moved in keep mode");

  AST_POST_INC: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_read and (mode == PMT_MODE_POST_INC && !req.wr_ptr_en) |=>
    table_pointer == $past(table_pointer) + PMT_PTR_ONE && byte_sel == $past(table_pointer[0]))
    else $error("post increment wrong");

  AST_POST_DEC: assert property (@(posedge clk) disable iff (!rst_b)
    start && mode == PMT_MODE_POST_DEC |=> table_pointer == $past(table_pointer) - PMT_PTR_ONE)
    else $error("post decrement wrong");

  AST_PRE_INC: assert property (@(posedge clk) disable iff (!rst_b)
    start && mode == PMT_MODE_PRE_INC |=> byte_sel == table_pointer[0])
    else $error("pre increment did not access moved address");

  AST_READ_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_read |=> ##1 table_latch == $past(fetched_byte))
    else $error("latch not loaded from selected byte");

  AST_MEM_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    mem.rd_en && mode != PMT_MODE_PRE_INC |-> mem.word_addr == (table_pointer >> 1))
    else $error("flash address not from pointer");

  AST_HOLD_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write |=> ##1 hold_mem[$past(hold_idx)] == $past(table_latch))
    else $error("holding register not written");

  AST_NO_READ_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write |-> !mem.rd_en)
    else $error("flash accessed by table write");

  // Opcode pattern seen by the checks, built from the package fields
  sequence s_idle_table_opc;
    state == PMT_IDLE && req.valid && req.opcode[PMT_OPC_W-1:3] == PMT_OPC_FIXED[13:1];
  endsequence

  sequence s_idle_read_opc;
    s_idle_table_opc ##0 !req.opcode[PMT_OPC_DIR_BIT];
  endsequence

  sequence s_idle_write_opc;
    s_idle_table_opc ##0 req.opcode[PMT_OPC_DIR_BIT];
  endsequence

  sequence s_read_low;
    s_start_read ##0 !access_addr[0];
  endsequence

  sequence s_read_high;
    s_start_read ##0 access_addr[0];
  endsequence

  sequence s_write_pre;
    s_start_write ##0 mode == PMT_MODE_PRE_INC;
  endsequence

  sequence s_write_not_pre;
    s_start_write ##0 mode != PMT_MODE_PRE_INC;
  endsequence

  // Checks on decode, foreign opcodes, pointer wrap, byte select, table writes, holding registers and the done pulse
  AST_DECODE_READ: assert property (@(posedge clk) disable iff (!rst_b)
    s_idle_read_opc |-> mem.rd_en ##1 done)
    else $error("table read opcode not executed");

  AST_DECODE_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    s_idle_write_opc |-> !mem.rd_en ##1 done)
    else $error("table write opcode not executed");

  AST_DECODE_FOREIGN: assert property (@(posedge clk) disable iff (!rst_b)
    state == PMT_IDLE && !(req.valid && req.opcode[PMT_OPC_W-1:3] == PMT_OPC_FIXED[13:1])
    |=> !done)
    else $error("foreign opcode started an access");

  AST_FOREIGN_NO_FETCH: assert property (@(posedge clk) disable iff (!rst_b)
    state == PMT_IDLE && !(req.valid && req.opcode[PMT_OPC_W-1:3] == PMT_OPC_FIXED[13:1])
    |-> !mem.rd_en)
    else $error("foreign opcode fetched from flash");

  AST_PTR_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    start && mode == PMT_MODE_POST_INC && table_pointer == {PMT_PTR_W{1'b1}}
    |=> table_pointer == '0)
    else $error("pointer did not wrap in its address space");

  AST_PRE_INC_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    mem.rd_en && mode == PMT_MODE_PRE_INC
    |-> mem.word_addr == ((table_pointer + PMT_PTR_ONE) >> 1))
    else $error("pre increment read used the old address");

  AST_LOW_BYTE: assert property (@(posedge clk) disable iff (!rst_b)
    s_read_low |=> ##1 table_latch == $past(mem_word[7:0]))
    else $error("even pointer did not take the low byte");

  AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (!rst_b)
    s_read_high |=> ##1 table_latch == $past(mem_word[15:8]))
    else $error("odd pointer did not take the high byte");

  AST_WRITE_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write ##0 mode == PMT_MODE_KEEP |=> table_pointer == $past(table_pointer))
    else $error("table write moved the pointer in keep mode");

  AST_WRITE_POST_INC: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write ##0 mode == PMT_MODE_POST_INC
    |=> table_pointer == $past(table_pointer) + PMT_PTR_ONE)
    else $error("table write did not post increment");

  AST_WRITE_POST_DEC: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write ##0 mode == PMT_MODE_POST_DEC
    |=> table_pointer == $past(table_pointer) - PMT_PTR_ONE)
    else $error("table write did not post decrement");

  AST_HOLD_PRE_INC: assert property (@(posedge clk) disable iff (!rst_b)
    s_write_pre |=> ##1 hold_mem[$past(ptr_low)] == $past(table_latch))
    else $error("pre increment write used the old holding index");

  AST_HOLD_INDEX: assert property (@(posedge clk) disable iff (!rst_b)
    s_write_not_pre |=> ##1 hold_mem[$past(ptr_low, 2)] == $past(table_latch))
    else $error("holding index not taken from the pointer");

  AST_HOLD_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    !op_write |=> hold_data == $past(hold_data))
    else $error("holding register changed without a table write");

  AST_LATCH_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_write ##0 !req.wr_latch_en |=> ##1 table_latch == $past(table_latch, 2))
    else $error("table write altered the latch");

  AST_BUSY_HOLDS_PTR: assert property (@(posedge clk) disable iff (!rst_b)
    busy |=> table_pointer == $past(table_pointer))
    else $error("pointer moved in the second cycle");

  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    done |=> !done)
    else $error("done stood for more than one cycle");

endmodule

// >>> sim/pmt_flash_model.sv
// Behavioural program flash read port for the table access bench
module pmt_flash_model
  import pmt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Flash read port
  input  wire pmt_pkg::pmt_mem_t mem,
  output logic [15:0]            mem_word
);
  timeunit 1ns;
  timeprecision 1ps;

  // Word content follows its address so the bench can predict every byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_word <= 16'h0000;
    end else if (mem.rd_en) begin
      mem_word <= {mem.word_addr[7:0] ^ 8'h5a, mem.word_addr[7:0]};
    end else begin
      // Outside a read the data is not held
      mem_word <= ~mem_word;
    end
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench of the program memory table access unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  pmt_req_t    req = '0;
  logic        busy;
  logic        done;
  logic [20:0] table_pointer;
  logic [7:0]  table_latch;
  pmt_mem_t    mem;
  logic [15:0] mem_word;
  logic [63:0] hold_data;
  int          bad_count = 0;
  int          n_compared = 0;

  always #20 clk = ~clk;

  pmt_table_access pmt_table_access_inst (.clk(clk), .rst_b(rst_b), .req(req), .busy(busy),
    .done(done), .table_pointer(table_pointer), .table_latch(table_latch), .mem(mem),
    .mem_word(mem_word), .hold_data(hold_data));
  pmt_flash_model pmt_flash_model_inst (.clk(clk), .rst_b(rst_b), .mem(mem),
    .mem_word(mem_word));

  function automatic logic [7:0] byte_at(input logic [20:0] a);
    return a[0] ? (a[8:1] ^ 8'h5a) : a[8:1];
  endfunction

  function automatic logic [20:0] addr_of(input logic [20:0] p, input int m);
    return (m == 3) ? p + 21'h1 : p;
  endfunction

  function automatic logic [20:0] after_of(input logic [20:0] p, input int m);
    return (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
  endfunction

  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic load(input logic [20:0] p, input logic [7:0] v);
    req.wr_ptr = p;
    req.wr_ptr_en = 1'b1;
    req.wr_latch = v;
    req.wr_latch_en = 1'b1;
    @(posedge clk);
    #1;
    req.wr_ptr_en = 1'b0;
    req.wr_latch_en = 1'b0;
  endtask

  // One instruction; returns in the cycle after done so the next may follow
  task automatic exec(input logic [15:0] opc, input logic [20:0] a);
    req.valid = 1'b1;
    req.opcode = opc;
    #1;
    check(mem.rd_en === !opc[2], "read strobe");
    if (!opc[2]) check(mem.word_addr === a[20:1], "word address");
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    check(done === 1'b1 && busy === 1'b1, "second cycle");
    @(posedge clk);
    #1;
    check(done === 1'b0, "done length");
  endtask

  task automatic t_reset;
    check(table_pointer === 21'h000000 && table_latch === 8'h00, "reset state");
    check(hold_data === 64'h0 && busy === 1'b0, "reset holding");
  endtask

  task automatic t_read;
    logic [20:0] p;
    for (int m = 0; m < 4; m++) begin
      p = 21'h00a356 + 21'(m);
      load(p, 8'h55);
      exec(16'h0008 | 16'(m), addr_of(p, m));
      check(table_latch === byte_at(addr_of(p, m)), "read byte");
      check(table_pointer === after_of(p, m), "read pointer");
    end
  endtask

  task automatic t_wrap;
    load(21'h1fffff, 8'h00);
    exec(16'h0009, 21'h1fffff);
    check(table_latch === byte_at(21'h1fffff) && table_pointer === 21'h0, "wrap up");
    exec(16'h000a, 21'h000000);
    check(table_latch === byte_at(21'h0) && table_pointer === 21'h1fffff, "wrap down");
  endtask

  task automatic t_write;
    logic [20:0] p;
    logic [7:0]  v;
    logic [20:0] a;
    for (int m = 0; m < 4; m++) begin
      p = 21'h01389a + 21'(m * 3);
      v = 8'h30 + 8'(m);
      a = addr_of(p, m);
      load(p, v);
      exec(16'h000c | 16'(m), a);
      check(hold_data[8*a[2:0] +: 8] === v, "holding byte");
      check(table_pointer === after_of(p, m) && table_latch === v, "write ptr");
    end
  endtask

  task automatic t_ignore;
    load(21'h000123, 8'h77);
    req.valid = 1'b1;
    req.opcode = 16'h0018;
    @(posedge clk);
    #1;
    check(done === 1'b0 && table_pointer === 21'h000123, "foreign opcode");
    req.opcode = 16'h0009;
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    req.wr_ptr = 21'h000000;
    req.wr_ptr_en = 1'b1;
    @(posedge clk);
    #1;
    req.wr_ptr_en = 1'b0;
    check(table_pointer === 21'h000124, "write while busy");
    check(table_latch === byte_at(21'h000123), "latch after refusal");
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_read();
    t_wrap();
    t_write();
    t_ignore();
    results();
  end

  initial begin
    #100us;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
endmodule
